// ==== hdl/tec_map.svh ====
// Register map, field positions and reset values for the timer run and
// external interrupt flag block. Included by the design files.
`ifndef TEC_MAP_SVH
`define TEC_MAP_SVH

// Special-function-register addresses
`define TEC_ADDR_CTRL      8'h88
`define TEC_ADDR_PWR       8'h87

// Control register field positions
`define TEC_T1_OVF_BIT     7
`define TEC_T1_RUN_BIT     6
`define TEC_T0_OVF_BIT     5
`define TEC_T0_RUN_BIT     4
`define TEC_X1_REQ_BIT     3
`define TEC_X1_TYPE_BIT    2
`define TEC_X0_REQ_BIT     1
`define TEC_X0_TYPE_BIT    0

// Power control idle bit position
`define TEC_IDLE_BIT       0

// Reset values
`define TEC_CTRL_RESET     8'h00

`endif

// ==== hdl/tec_pkg.sv ====
// Types shared by the timer run and external interrupt flag block.
// Assumes nothing beyond a SystemVerilog compiler.
package tec_pkg;

    // Detection mode of one external interrupt pin
    typedef enum logic {
        TEC_LEVEL,
        TEC_EDGE
    } tec_trig_t;

endpackage

// ==== hdl/tec_ext_irq.sv ====
// One external interrupt request flag with level or edge detection.
// Assumes the active-low pin is already synchronous to i_clk.
`timescale 1ns/10ps
`include "tec_map.svh"

module tec_ext_irq (
    input  wire logic           i_clk,
    input  wire logic           i_rstn,
    input  wire logic           i_pin_n,
    input  wire tec_pkg::tec_trig_t i_trig,
    input  wire logic           i_sw_clear,
    input  wire logic           i_sw_set,
    input  wire logic           i_vector_ack,
    output logic                o_flag
);

    logic pin_prev_reg;
    logic latch_reg;
    logic fall;

    //------------------------------------------------------------
    // Edge detect
    //------------------------------------------------------------
    // Previous sample; reset high so a pin already low at release counts as an edge
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            pin_prev_reg <= 1'b1;
        end else begin
            pin_prev_reg <= i_pin_n;  // (R11)
        end
    end

    assign fall = pin_prev_reg & ~i_pin_n;  // (R11)

    //------------------------------------------------------------
    // Latched request
    //------------------------------------------------------------
    // A fresh edge wins over a clear in the same cycle
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            latch_reg <= 1'b0;
        end else if (i_trig == tec_pkg::TEC_EDGE && fall) begin
            latch_reg <= 1'b1;  // (R5)
        end else if (i_sw_clear || i_vector_ack) begin
            latch_reg <= 1'b0;  // (R5)
        end else if (i_sw_set) begin
            latch_reg <= 1'b1;
        end
    end

    // Level mode shows the inverted pin, no latching
    assign o_flag = (i_trig == tec_pkg::TEC_EDGE) ? latch_reg : ~i_pin_n;  // (R6)

endmodule

// ==== hdl/tec_ctrl.sv ====
// Timer/counter control register with run bits, overflow flags and
// external interrupt flags, plus the run qualifiers for timers 0 and 1.
// Assumes a core-side SFR bus: one-cycle write strobe, address, data.
// Assumes overflow pulses and vector acknowledges are one cycle wide and
// synchronous; the count datapath lives outside and only sees the enables.
`timescale 1ns/10ps
`include "tec_map.svh"

// How it works
// (R1) Timer 1 overflow sets flag; software/vector clears
// (R2) Timer 1 runs only while run bit is 1
// (R3) Timer 0 overflow sets flag; software/vector clears
// (R4) Timer 0 runs only while run bit is 1
// (R5) Edge mode latches request until cleared
// (R6) Level mode flag shows inverted pin
// (R7) Interrupt 1 type bit selects level/edge
// (R8) Interrupt 0 type bit selects level/edge
// (R9) Idle freezes timers; idle reads zero
// (R10) Gate requires pin high for counting
// (R11) Falling edge found from successive samples
module tec_ctrl (
    input  wire logic       i_clk,
    input  wire logic       i_rstn,
    input  wire logic [7:0] i_sfr_addr,
    input  wire logic       i_sfr_wr,
    input  wire logic [7:0] i_sfr_wdata,
    output logic      [7:0] o_sfr_rdata,
    input  wire logic       i_t0_overflow,
    input  wire logic       i_t1_overflow,
    input  wire logic       i_t0_vector_ack,
    input  wire logic       i_t1_vector_ack,
    input  wire logic       i_x0_vector_ack,
    input  wire logic       i_x1_vector_ack,
    input  wire logic       i_t0_gate,
    input  wire logic       i_t1_gate,
    input  wire logic       i_ext_irq0_pin_n,
    input  wire logic       i_ext_irq1_pin_n,
    output logic            o_timer0_count_en,
    output logic            o_timer1_count_en,
    output logic            o_idle
);

    // Control register bits kept in flip-flops
    logic       timer1_overflow_flag_reg;
    logic       timer0_overflow_flag_reg;
    logic       timer1_run_reg;
    logic       timer0_run_reg;
    logic       ext_irq1_trigger_type_reg;
    logic       ext_irq0_trigger_type_reg;

    // Idle bit of the power control register
    logic       idle_reg;

    // Request flags as the control register shows them
    logic       ext_irq1_request_flag;
    logic       ext_irq0_request_flag;

    // Write decodes and per-flag software strobes
    logic       ctrl_wr;
    logic       pwr_wr;
    logic       x1_sw_clear;
    logic       x1_sw_set;
    logic       x0_sw_clear;
    logic       x0_sw_set;

    // Gate qualifiers for the count enables
    logic       timer1_gate_ok;
    logic       timer0_gate_ok;

    // Readback value of the control register
    logic [7:0] ctrl_val;

    //------------------------------------------------------------
    // Address decode
    //------------------------------------------------------------
    // Shared decode for write and read paths
    // Full eight-bit compare; neighbouring addresses belong to other blocks
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
        hit = (a == ref_a);
    endfunction

    assign ctrl_wr = i_sfr_wr & hit(i_sfr_addr, `TEC_ADDR_CTRL);
    assign pwr_wr  = i_sfr_wr & hit(i_sfr_addr, `TEC_ADDR_PWR);

    //------------------------------------------------------------
    // Overflow flags
    //------------------------------------------------------------
    // Hardware set beats software or vector clear so no overflow is lost
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            timer1_overflow_flag_reg <= 1'b0;
        end else if (i_t1_overflow) begin
            timer1_overflow_flag_reg <= 1'b1;  // (R1)
        end else if (ctrl_wr) begin
            timer1_overflow_flag_reg <= i_sfr_wdata[`TEC_T1_OVF_BIT];  // (R1)
        end else if (i_t1_vector_ack) begin
            timer1_overflow_flag_reg <= 1'b0;  // (R1)
        end
    end

    // Same priority for timer 0; a write landing on a wrap loses to the wrap
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            timer0_overflow_flag_reg <= 1'b0;
        end else if (i_t0_overflow) begin
            timer0_overflow_flag_reg <= 1'b1;  // (R3)
        end else if (ctrl_wr) begin
            timer0_overflow_flag_reg <= i_sfr_wdata[`TEC_T0_OVF_BIT];  // (R3)
        end else if (i_t0_vector_ack) begin
            timer0_overflow_flag_reg <= 1'b0;  // (R3)
        end
    end

    //------------------------------------------------------------
    // Run and type bits
    //------------------------------------------------------------
    // Run bits are software-owned; no hardware event touches them
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            timer1_run_reg <= 1'b0;
            timer0_run_reg <= 1'b0;
        end else if (ctrl_wr) begin
            timer1_run_reg <= i_sfr_wdata[`TEC_T1_RUN_BIT];  // (R2)
            timer0_run_reg <= i_sfr_wdata[`TEC_T0_RUN_BIT];  // (R4)
        end
    end

    // Trigger types; a change applies from the next pin sample on
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            ext_irq1_trigger_type_reg <= 1'b0;
            ext_irq0_trigger_type_reg <= 1'b0;
        end else if (ctrl_wr) begin
            ext_irq1_trigger_type_reg <= i_sfr_wdata[`TEC_X1_TYPE_BIT];  // (R7)
            ext_irq0_trigger_type_reg <= i_sfr_wdata[`TEC_X0_TYPE_BIT];  // (R8)
        end
    end

    //------------------------------------------------------------
    // Idle mode
    //------------------------------------------------------------
    // Only the idle bit of the power control register is kept here
    // Idle holds until reset or a power-control write of 0; wake-up lives outside this block
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            idle_reg <= 1'b0;
        end else if (pwr_wr) begin
            idle_reg <= i_sfr_wdata[`TEC_IDLE_BIT];  // (R9)
        end
    end

    assign o_idle = idle_reg;

    //------------------------------------------------------------
    // External interrupt flags
    //------------------------------------------------------------
    // Control writes load each latched request bit: 0 clears, 1 sets
    assign x1_sw_clear = ctrl_wr & ~i_sfr_wdata[`TEC_X1_REQ_BIT];  // (R5)
    assign x1_sw_set   = ctrl_wr & i_sfr_wdata[`TEC_X1_REQ_BIT];
    assign x0_sw_clear = ctrl_wr & ~i_sfr_wdata[`TEC_X0_REQ_BIT];  // (R5)
    assign x0_sw_set   = ctrl_wr & i_sfr_wdata[`TEC_X0_REQ_BIT];

    // The latch is hidden in level mode but still follows writes there
    // Software may write the latched flag; a write of 0 clears it
    tec_ext_irq u_x1 (
        .i_clk        (i_clk),
        .i_rstn       (i_rstn),
        .i_pin_n      (i_ext_irq1_pin_n),
        .i_trig       (tec_pkg::tec_trig_t'(ext_irq1_trigger_type_reg)),  // (R7)
        .i_sw_clear   (x1_sw_clear),
        .i_sw_set     (x1_sw_set),
        .i_vector_ack (i_x1_vector_ack),
        .o_flag       (ext_irq1_request_flag)
    );

    tec_ext_irq u_x0 (
        .i_clk        (i_clk),
        .i_rstn       (i_rstn),
        .i_pin_n      (i_ext_irq0_pin_n),
        .i_trig       (tec_pkg::tec_trig_t'(ext_irq0_trigger_type_reg)),  // (R8)
        .i_sw_clear   (x0_sw_clear),
        .i_sw_set     (x0_sw_set),
        .i_vector_ack (i_x0_vector_ack),
        .o_flag       (ext_irq0_request_flag)
    );

    //------------------------------------------------------------
    // Count enables
    //------------------------------------------------------------
    // Gate clear: pin ignored, run bit and idle decide; gate set: the pin must also be high
    assign timer1_gate_ok = ~i_t1_gate | i_ext_irq1_pin_n;  // (R10)
    assign timer0_gate_ok = ~i_t0_gate | i_ext_irq0_pin_n;  // (R10)

    // Halted timers keep their count because the datapath sees no enable;
    // combinational, so a stop takes effect on the very next count edge
    assign o_timer1_count_en = timer1_run_reg & ~idle_reg & timer1_gate_ok;  // (R2) (R9)
    assign o_timer0_count_en = timer0_run_reg & ~idle_reg & timer0_gate_ok;  // (R4) (R9)

    //------------------------------------------------------------
    // Read path
    //------------------------------------------------------------
    // Bit order follows the register: timer bits high, interrupt bits low
    always_comb begin
        ctrl_val = {timer1_overflow_flag_reg, timer1_run_reg,
                    timer0_overflow_flag_reg, timer0_run_reg,
                    ext_irq1_request_flag, ext_irq1_trigger_type_reg,
                    ext_irq0_request_flag, ext_irq0_trigger_type_reg};
    end

    // A read answers one edge after the address; the core must allow for it
    // Registered read data; idle bit always reads zero, other addresses zero
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_sfr_rdata <= `TEC_CTRL_RESET;
        end else if (hit(i_sfr_addr, `TEC_ADDR_CTRL)) begin
            o_sfr_rdata <= ctrl_val;
        end else begin
            o_sfr_rdata <= 8'h00;  // (R9)
        end
    end

endmodule

// ==== test/tec_ctrl_sva.sv ====
// Port checks for the timer control block.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/10ps
module tec_ctrl_sva (
    input wire logic       i_clk,
    input wire logic       i_rstn,
    input wire logic [7:0] i_sfr_addr,
    input wire logic       i_sfr_wr,
    input wire logic [7:0] i_sfr_wdata,
    input wire logic [7:0] o_sfr_rdata,
    input wire logic       i_t0_overflow,
    input wire logic       i_t1_overflow,
    input wire logic       i_t0_vector_ack,
    input wire logic       i_t1_gate,
    input wire logic       i_ext_irq0_pin_n,
    input wire logic       i_ext_irq1_pin_n,
    input wire logic       o_timer0_count_en,
    input wire logic       o_timer1_count_en,
    input wire logic       o_idle
);
    // ----
    // Properties
    // ----
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    property p_t1_set;
        i_t1_overflow ##1 i_sfr_addr == 8'h88 |=> o_sfr_rdata[7];
    endproperty
    a_t1_set: assert property (p_t1_set) else $error("overflow flag not set");
    property p_t0_clr;
        i_t0_vector_ack && !i_t0_overflow && !i_sfr_wr ##1 i_sfr_addr == 8'h88 |=> !o_sfr_rdata[5];
    endproperty
    a_t0_clr: assert property (p_t0_clr) else $error("vector ack did not clear");
    property p_run1;
        i_sfr_wr && i_sfr_addr == 8'h88 && i_sfr_wdata[6] && !o_idle
            |=> o_timer1_count_en == (!i_t1_gate || i_ext_irq1_pin_n);
    endproperty
    a_run1: assert property (p_run1) else $error("run bit did not enable");
    property p_idle_stop;
        o_idle |-> !o_timer0_count_en && !o_timer1_count_en;
    endproperty
    a_idle_stop: assert property (p_idle_stop) else $error("timer counts in idle");
    property p_idle_wr;
        i_sfr_wr && i_sfr_addr == 8'h87 |=> o_idle == $past(i_sfr_wdata[0]);
    endproperty
    a_idle_wr: assert property (p_idle_wr) else $error("idle write lost");
    property p_gate1;
        o_timer1_count_en && i_t1_gate |-> i_ext_irq1_pin_n;
    endproperty
    a_gate1: assert property (p_gate1) else $error("gated timer counts");
    property p_other;
        i_sfr_addr != 8'h88 |=> o_sfr_rdata == 8'h00;
    endproperty
    a_other: assert property (p_other) else $error("other address reads nonzero");
    property p_lvl0;
        $past(i_sfr_addr) == 8'h88 && !$past(i_sfr_wr) && i_sfr_addr == 8'h88 && !o_sfr_rdata[0]
            |=> o_sfr_rdata[1] == !$past(i_ext_irq0_pin_n);
    endproperty
    a_lvl0: assert property (p_lvl0) else $error("level flag wrong");
endmodule

bind tec_ctrl tec_ctrl_sva u_sva (.i_clk(i_clk), .i_rstn(i_rstn), .i_sfr_addr(i_sfr_addr),
    .i_sfr_wr(i_sfr_wr), .i_sfr_wdata(i_sfr_wdata), .o_sfr_rdata(o_sfr_rdata),
    .i_t0_overflow(i_t0_overflow), .i_t1_overflow(i_t1_overflow), .i_t0_vector_ack(i_t0_vector_ack),
    .i_t1_gate(i_t1_gate), .i_ext_irq0_pin_n(i_ext_irq0_pin_n), .i_ext_irq1_pin_n(i_ext_irq1_pin_n),
    .o_timer0_count_en(o_timer0_count_en), .o_timer1_count_en(o_timer1_count_en), .o_idle(o_idle));

// ==== test/tec_timer_model.sv ====
// Timer datapath stand-in: counts while enabled, pulses on wrap.
// Assumes its enable comes from the block's count enable.
`timescale 1ns/10ps
module tec_timer_model #(
    parameter int W = 4
) (
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    input  wire logic         i_en,
    output logic      [W-1:0] o_count,
    output logic              o_overflow
);
    // Count holds while disabled; short width keeps runs brief
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_count <= '0;
        end else if (i_en) begin
            o_count <= o_count + 1'b1;
        end
    end
    assign o_overflow = i_en && (&o_count);
endmodule

// ==== test/test_tec_ctrl.sv ====
// Self-checking bench for the timer control block.
// Assumes the checker is bound and the timer stand-ins are present.
`timescale 1ns/10ps
module test_tec_ctrl;
    logic       i_clk = 1'b0;
    logic       i_rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [7:0] wdata = 8'h00;
    logic       wr = 1'b0;
    logic [3:0] ack = 4'h0;
    logic [1:0] gate = 2'h0;
    logic [1:0] pin_n = 2'h3;
    logic [7:0] rdata;
    logic       en0, en1, idle, ov0, ov1;
    logic [3:0] c0, c1, hold;
    int         miscompares = 0;
    int         samples_checked = 0;

    always #2.5 i_clk = ~i_clk;
    tec_ctrl uut (.i_clk(i_clk), .i_rstn(i_rstn), .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_wdata(wdata),
        .o_sfr_rdata(rdata), .i_t0_overflow(ov0), .i_t1_overflow(ov1), .i_t0_vector_ack(ack[0]),
        .i_t1_vector_ack(ack[1]), .i_x0_vector_ack(ack[2]), .i_x1_vector_ack(ack[3]), .i_t0_gate(gate[0]),
        .i_t1_gate(gate[1]), .i_ext_irq0_pin_n(pin_n[0]), .i_ext_irq1_pin_n(pin_n[1]),
        .o_timer0_count_en(en0), .o_timer1_count_en(en1), .o_idle(idle));
    tec_timer_model #(.W(4)) u_t0 (.i_clk(i_clk), .i_rstn(i_rstn), .i_en(en0), .o_count(c0), .o_overflow(ov0));
    tec_timer_model #(.W(4)) u_t1 (.i_clk(i_clk), .i_rstn(i_rstn), .i_en(en1), .o_count(c1), .o_overflow(ov1));

    // ----
    // Bus cycles and compare
    // ----
    // Callers wait 1 ns first: arguments are taken at the call, after settling
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge i_clk);
        wr <= 1'b0;
    endtask
    // Read data lands one edge after the address
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge i_clk);
        addr <= a;
        @(posedge i_clk);
        #1 chk(rdata, exp);
    endtask
    task automatic pulse(input int i);
        @(posedge i_clk);
        ack[i] <= 1'b1;
        @(posedge i_clk);
        ack[i] <= 1'b0;
    endtask

    // ----
    // Scenarios
    // ----
    task automatic t_timers();
        wr_reg(8'h88, 8'h50);
        #1 chk({6'h0, en1, en0}, 8'h03);
        repeat (17) @(posedge i_clk);
        rd_reg(8'h88, 8'hf0);
        wr_reg(8'h88, 8'ha0);
        #1 hold = c0;
        repeat (5) @(posedge i_clk);
        #1 chk({c1, c0}, {hold, hold});
        pulse(1);
        rd_reg(8'h88, 8'h20);
        pulse(0);
        rd_reg(8'h88, 8'h00);
    endtask
    task automatic t_gate_idle();
        wr_reg(8'h88, 8'h50);
        gate <= 2'h3;
        pin_n <= 2'h2;
        #1 chk({6'h0, en1, en0}, 8'h02);
        @(posedge i_clk);
        pin_n <= 2'h3;
        wr_reg(8'h87, 8'h01);
        #1 chk({5'h0, idle, en1, en0}, 8'h04);
        rd_reg(8'h87, 8'h00);
        wr_reg(8'h87, 8'h00);
        gate <= 2'h0;
        #1 chk({5'h0, idle, en1, en0}, 8'h03);
        // Second clear: a wrap may coincide with the first and win
        wr_reg(8'h88, 8'h00);
        wr_reg(8'h88, 8'h00);
    endtask
    task automatic t_ext();
        pin_n <= 2'h0;
        rd_reg(8'h88, 8'h0a);
        wr_reg(8'h88, 8'h05);
        pin_n <= 2'h3;
        rd_reg(8'h88, 8'h05);
        @(posedge i_clk);
        pin_n <= 2'h0;
        @(posedge i_clk);
        pin_n <= 2'h3;
        rd_reg(8'h88, 8'h0f);
        pulse(2);
        rd_reg(8'h88, 8'h0d);
        wr_reg(8'h88, 8'h05);
        rd_reg(8'h88, 8'h05);
        // Edge on the interrupt 1 pin only, then its own vector clears it
        @(posedge i_clk);
        pin_n <= 2'h1;
        @(posedge i_clk);
        pin_n <= 2'h3;
        rd_reg(8'h88, 8'h0d);
        pulse(3);
        rd_reg(8'h88, 8'h05);
        rd_reg(8'h8a, 8'h00);
    endtask

    task automatic stop_test();
        $display("Checked %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge i_clk);
        i_rstn <= 1'b1;
        rd_reg(8'h88, 8'h00);
        t_timers();
        t_gate_idle();
        t_ext();
        stop_test();
    end
    // Watchdog: the sequence needs well under 1000 cycles
    initial begin
        #5000;
        miscompares++;
        stop_test();
    end
endmodule
